// *** dsrf_pkg.sv ***
// dsrf_pkg: constants, types and helpers of the dual-state register file
// assumes a single core clock domain; all users write dsrf_pkg::name
//
// Overview of operation
// - thirty-one 64-bit general registers, open to every privilege level
// - 32-bit state sees only low word; upper word never reachable
// - banked 32-bit mode registers live in spare 64-bit registers 15-30
// - saved status and hypervisor return kept apart, system window only
// - supervisor/hypervisor saved status and return share level 1/2 storage
// - abort, undefined, irq, fiq saved status kept while level 1 is 64-bit
// - in 64-bit state those saved status registers need a higher level
// - exception from 32-bit into 64-bit clears target return upper word
// - 32-bit state adds saturation, ge, if-then, j, isa, endian, mode
// - thirty-two 128-bit vector registers for fp and simd operands
// - scalar access uses low bits; reads ignore, writes zero the rest
// - byte, half, single, double, quad views are low bits of same n
// - half precision only for conversion, never as arithmetic operand
// - vector shapes 8x8,4x16,2x32,1x64 and 16x8,8x16,4x32,2x64
// - 32-bit state fp registers map into the 64-bit vector registers
// - vectors 16 to 31 unreachable and unchanged in 32-bit state
// - entering 64-bit from 32-bit, reachable upper halves undefined
// - level 0-2 stack pointers and level 1 return survive 32-bit runs
package dsrf_pkg;

  localparam int unsigned NUM_GPR = 31;
  localparam int unsigned GPR_W   = 64;
  localparam int unsigned NUM_VEC = 32;
  localparam int unsigned VEC_W   = 128;
  localparam int unsigned NUM_SST = 7;

  // bus transfer sequencer, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_RESP = 3'b100
  } dsrf_bus_state_e;

  // single registers, byte addresses
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_EXC_ADDR = 12'h008;
  localparam logic [11:0] OFF_EXC_GO   = 12'h00c;
  localparam logic [11:0] OFF_LEGACY   = 12'h010;
  // windows, selected by address bits [11:8] (vector window by [11:9])
  localparam logic [3:0]  WIN_GPR  = 4'h1;
  localparam logic [3:0]  WIN_BANK = 4'h2;
  localparam logic [3:0]  WIN_SYS  = 4'h3;
  localparam logic [2:0]  WIN_VEC  = 3'h2;
  localparam logic [3:0]  WIN_SCAL = 4'h6;
  localparam logic [3:0]  WIN_DBL  = 4'h7;
  localparam logic [3:0]  WIN_ELEM = 4'h8;
  localparam logic [2:0]  SYS_SST  = 3'h0;
  localparam logic [2:0]  SYS_ERA  = 3'h1;
  localparam logic [2:0]  SYS_SP   = 3'h2;

  // control register layout
  localparam int unsigned CTRL_ST32_BIT  = 0;
  localparam int unsigned CTRL_LVL_LSB   = 1;
  localparam int unsigned CTRL_VIEW_LSB  = 3;
  localparam int unsigned CTRL_SHAPE_LSB = 6;
  localparam int unsigned CTRL_ELEM_LSB  = 9;
  localparam int unsigned CTRL_FPA_BIT   = 13;
  localparam logic [31:0] CTRL_MASK      = 32'h0000_3fff;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam int unsigned STAT_REFUSED_BIT = 0;

  // legacy processor state layout
  localparam int unsigned LPS_MODE_LSB = 0;
  localparam int unsigned LPS_ISA_BIT  = 5;
  localparam int unsigned LPS_END_BIT  = 9;
  localparam int unsigned LPS_ITL_LSB  = 10;
  localparam int unsigned LPS_GE_LSB   = 16;
  localparam int unsigned LPS_J_BIT    = 24;
  localparam int unsigned LPS_ITH_LSB  = 25;
  localparam int unsigned LPS_Q_BIT    = 27;
  localparam logic [31:0] LPS_MASK     = 32'h0f0f_fe3f;
  localparam logic [31:0] LPS_RESET    = 32'h0000_0003;

  // 32-bit state modes (mode field)
  localparam logic [4:0] MODE_USR = 5'h00;
  localparam logic [4:0] MODE_FIQ = 5'h01;
  localparam logic [4:0] MODE_IRQ = 5'h02;
  localparam logic [4:0] MODE_SVC = 5'h03;
  localparam logic [4:0] MODE_MON = 5'h04;
  localparam logic [4:0] MODE_ABT = 5'h05;
  localparam logic [4:0] MODE_HYP = 5'h06;
  localparam logic [4:0] MODE_UND = 5'h07;
  localparam logic [4:0] MODE_SYS = 5'h08;

  // saved status slots; levels 1..3 share slots 0..2
  localparam logic [2:0] SST_ABT = 3'h3;
  localparam logic [2:0] SST_NONE = 3'h7;

  // banked register homes in the 64-bit file
  localparam logic [4:0] FIQ_BASE = 5'h18;
  localparam logic [4:0] FIQ_SP = 5'h1d;
  localparam logic [4:0] FIQ_LR = 5'h1e;
  localparam logic [4:0] IRQ_SP = 5'h11;
  localparam logic [4:0] IRQ_LR = 5'h10;
  localparam logic [4:0] ABT_SP = 5'h15;
  localparam logic [4:0] ABT_LR = 5'h14;
  localparam logic [4:0] SVC_SP = 5'h13;
  localparam logic [4:0] SVC_LR = 5'h12;
  localparam logic [4:0] UND_SP = 5'h17;
  localparam logic [4:0] UND_LR = 5'h16;
  localparam logic [4:0] HYP_SP = 5'h0f;
  localparam logic [4:0] NO_REG = 5'h1f;

  // scalar view sizes
  localparam logic [2:0] VIEW_BYTE = 3'h0;
  localparam logic [2:0] VIEW_HALF = 3'h1;
  localparam logic [2:0] VIEW_SNGL = 3'h2;
  localparam logic [2:0] VIEW_DBL  = 3'h3;
  localparam logic [2:0] VIEW_QUAD = 3'h4;

  // 32-bit register r in given mode -> 64-bit file index
  function automatic logic [4:0] bank_idx(input logic [4:0] mode,
                                          input logic [3:0] r);
    logic [4:0] idx;
    idx = {1'b0, r};
    if (r == 4'hf) begin
      idx = NO_REG;
    end else if (mode == MODE_FIQ && r >= 4'h8) begin
      idx = FIQ_BASE + {1'b0, r - 4'h8};
    end else if (r == 4'hd) begin
      case (mode)
        MODE_IRQ: idx = IRQ_SP;
        MODE_ABT: idx = ABT_SP;
        MODE_SVC: idx = SVC_SP;
        MODE_UND: idx = UND_SP;
        MODE_HYP: idx = HYP_SP;
        default:  idx = 5'h0d;
      endcase
    end else if (r == 4'he) begin
      case (mode)
        MODE_IRQ: idx = IRQ_LR;
        MODE_ABT: idx = ABT_LR;
        MODE_SVC: idx = SVC_LR;
        MODE_UND: idx = UND_LR;
        default:  idx = 5'h0e;
      endcase
    end
    return idx;
  endfunction

  // bits of word 0 that a scalar view keeps
  function automatic logic [31:0] view_mask(input logic [2:0] v);
    return (v == VIEW_BYTE) ? 32'h0000_00ff :
           (v == VIEW_HALF) ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction

  // words written by a scalar store: data to word 0, zeros above the view
  function automatic logic [3:0] scal_wen(input logic [2:0] v);
    return (v == VIEW_DBL) ? 4'b1101 :
           (v == VIEW_QUAD) ? 4'b0001 : 4'b1111;
  endfunction

  // shape: [2:1] element size log2(bytes), [0] 128-bit vector
  function automatic logic elem_ok(input logic [2:0] shape,
                                   input logic [3:0] idx);
    int lanes;
    lanes = (8 << shape[0]) >> shape[2:1];
    return int'(idx) < lanes;
  endfunction

  function automatic logic [63:0] elem_get(input logic [127:0] v,
                                           input logic [2:0] shape,
                                           input logic [3:0] idx);
    logic [127:0] s;
    logic [63:0]  m;
    s = v >> (int'(idx) * (8 << shape[2:1]));
    m = (shape[2:1] == 2'h3) ? 64'hffff_ffff_ffff_ffff :
        ((64'h1 << (8 << shape[2:1])) - 64'h1);
    return s[63:0] & m;
  endfunction

endpackage

// *** dsrf_vmem_if.sv ***
// dsrf_vmem_if: carrier between the register file and its vector store
// assumes both ends run on the core clock
interface dsrf_vmem_if;
  logic [4:0]                  addr;
  logic [3:0]                  wr_en;
  logic [dsrf_pkg::VEC_W-1:0] wr_data;
  logic [dsrf_pkg::VEC_W-1:0] rd_data;
  modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
  modport mem  (input addr, input wr_en, input wr_data, output rd_data);
endinterface

// *** dsrf_vmem.sv ***
// dsrf_vmem: 32 x 128-bit vector register store, per-word write enables
// assumes one address for read and write; read data is registered
module dsrf_vmem (
  input wire logic core_clk_in,  // core clock
  dsrf_vmem_if.mem port_if       // access from the register file
);

  logic [dsrf_pkg::VEC_W-1:0] mem_ff [dsrf_pkg::NUM_VEC];
  logic [dsrf_pkg::VEC_W-1:0] rd_ff;

  // no reset on storage: a read-before-write returns old (undefined) data
  always_ff @(posedge core_clk_in) begin
    for (int w = 0; w < 4; w++) begin
      if (port_if.wr_en[w]) begin
        mem_ff[port_if.addr][w*32 +: 32] <= port_if.wr_data[w*32 +: 32];
      end
    end
    rd_ff <= mem_ff[port_if.addr];
  end

  assign port_if.rd_data = rd_ff;

endmodule

// *** dsrf_top.sv ***
// dsrf_top: dual-state architectural register file behind an ahb-lite slave
// assumes one ahb-lite master, single word transfers, core clock only
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
module dsrf_top (
  input  wire logic        core_clk_in,   // core clock, 20 mhz
  input  wire logic        rst_n_in,      // synchronous reset, active low
  input  wire logic        hsel_in,       // slave select
  input  wire logic [31:0] haddr_in,      // byte address
  input  wire logic [1:0]  htrans_in,     // transfer type
  input  wire logic        hwrite_in,     // write when high
  input  wire logic [2:0]  hsize_in,      // transfer size (word only)
  input  wire logic [31:0] hwdata_in,     // write data
  input  wire logic        hready_in,     // bus ready
  output logic      [31:0] hrdata_out,    // read data
  output logic             hreadyout_out, // slave ready
  output logic             hresp_out,     // always okay
  output logic             state32_out,   // 32-bit execution state active
  output logic      [1:0]  level_out      // current privilege level
);

  dsrf_pkg::dsrf_bus_state_e state_ff, nxt_state;
  logic [11:0] addr_ff;
  logic        addr_hi_ff, wr_ff, hready_ff, hresp_ff, refused_ff;
  logic [31:0] ctrl_ff, lps_ff, exc_addr_ff, hrdata_ff;
  logic [63:0] gpr_ff [dsrf_pkg::NUM_GPR];
  logic [31:0] sst_ff [dsrf_pkg::NUM_SST];
  logic [63:0] era_ff [4];
  logic [63:0] sp_ff  [3];

  dsrf_vmem_if vm ();

  dsrf_vmem u_vmem (
    .core_clk_in (core_clk_in),
    .port_if     (vm.mem)
  );

  // control fields
  wire       st32  = ctrl_ff[dsrf_pkg::CTRL_ST32_BIT];
  wire [1:0] lvl   = ctrl_ff[dsrf_pkg::CTRL_LVL_LSB +: 2];
  wire [2:0] view  = ctrl_ff[dsrf_pkg::CTRL_VIEW_LSB +: 3];
  wire [2:0] shape = ctrl_ff[dsrf_pkg::CTRL_SHAPE_LSB +: 3];
  wire [3:0] eidx  = ctrl_ff[dsrf_pkg::CTRL_ELEM_LSB +: 4];
  wire       fpa   = ctrl_ff[dsrf_pkg::CTRL_FPA_BIT];
  wire [4:0] mode  = lps_ff[dsrf_pkg::LPS_MODE_LSB +: 5];

  // bus handshake
  wire take   = hsel_in & htrans_in[1] & hready_in &
                (state_ff == dsrf_pkg::ST_IDLE);
  wire exec   = (state_ff == dsrf_pkg::ST_EXEC);
  wire wr_now = exec & wr_ff;
  wire [3:0] win = addr_ff[11:8];
  wire [2:0] sys = addr_ff[7:5];

  // single registers
  wire sel_ctrl = !addr_hi_ff && addr_ff == dsrf_pkg::OFF_CTRL;
  wire sel_stat = !addr_hi_ff && addr_ff == dsrf_pkg::OFF_STATUS;
  wire sel_exca = !addr_hi_ff && addr_ff == dsrf_pkg::OFF_EXC_ADDR;
  wire sel_excg = !addr_hi_ff && addr_ff == dsrf_pkg::OFF_EXC_GO;
  wire sel_lps  = !addr_hi_ff && addr_ff == dsrf_pkg::OFF_LEGACY;
  wire [1:0] exc_tgt = hwdata_in[1:0];
  wire ok_excg  = sel_excg & wr_ff & (exc_tgt != 2'h0);
  wire ok_lps   = sel_lps & st32;

  // 64-bit view of the general file, 64-bit state only
  wire [4:0] gpr_i  = addr_ff[7:3];
  wire sel_gpr = !addr_hi_ff && win == dsrf_pkg::WIN_GPR && gpr_i != 5'h1f;
  wire ok_gpr  = sel_gpr & !st32;

  // banked 32-bit word view, 32-bit state only
  wire [4:0] bank_i = dsrf_pkg::bank_idx(mode, addr_ff[5:2]);
  wire sel_bank = !addr_hi_ff && win == dsrf_pkg::WIN_BANK &&
                  addr_ff[7:6] == 2'h0 && bank_i != dsrf_pkg::NO_REG;
  wire ok_bank  = sel_bank & st32;

  // system window: saved status, return addresses, stack pointers
  wire [2:0] sst_k = addr_ff[4:2];
  wire [1:0] sys_l = addr_ff[4:3];
  wire in_sys  = !addr_hi_ff && win == dsrf_pkg::WIN_SYS;
  wire sel_sst = in_sys && sys == dsrf_pkg::SYS_SST &&
                 sst_k != dsrf_pkg::SST_NONE;
  // legacy-only slots need level 2 or above while in 64-bit state
  wire ok_sst  = sel_sst & (st32 | ((sst_k < dsrf_pkg::SST_ABT) ?
                 ({1'b0, lvl} > sst_k) : (lvl >= 2'h2)));
  wire sel_era = in_sys && sys == dsrf_pkg::SYS_ERA && sys_l != 2'h0;
  // in 32-bit state only the hypervisor return word is reachable
  wire ok_era  = sel_era & (st32 ? (sys_l == 2'h2 && !addr_ff[2]) :
                 (lvl >= sys_l));
  wire sel_sp  = in_sys && sys == dsrf_pkg::SYS_SP && sys_l != 2'h3;
  wire ok_sp   = sel_sp & !st32 & (lvl >= sys_l);

  // vector windows
  wire sel_vec  = !addr_hi_ff && addr_ff[11:9] == dsrf_pkg::WIN_VEC;
  wire ok_vec   = sel_vec & (!st32 | !addr_ff[8]);
  wire sel_scal = !addr_hi_ff && win == dsrf_pkg::WIN_SCAL && !addr_ff[7];
  wire half_arith = fpa & (view == dsrf_pkg::VIEW_HALF);
  wire ok_scal  = sel_scal & !st32 & (view <= dsrf_pkg::VIEW_QUAD) &
                  !half_arith;
  wire [4:0] dbl_d = addr_ff[7:3];
  wire sel_dbl  = !addr_hi_ff && win == dsrf_pkg::WIN_DBL;
  wire ok_dbl   = sel_dbl & st32;
  wire sel_elem = !addr_hi_ff && win == dsrf_pkg::WIN_ELEM;
  wire ok_elem  = sel_elem & !st32 & !wr_ff &
                  dsrf_pkg::elem_ok(shape, eidx);

  wire ok_any = sel_ctrl | sel_stat | sel_exca | ok_excg | ok_lps |
                ok_gpr | ok_bank | ok_sst | ok_era | ok_sp |
                ok_vec | ok_scal | ok_dbl | ok_elem;

  // vector store addressing; double 2n+1 is the upper half of vector n
  wire [4:0] vn = sel_dbl  ? {1'b0, dbl_d[4:1]} :
                  sel_scal ? addr_ff[6:2] :
                  sel_elem ? addr_ff[7:3] : addr_ff[8:4];
  wire [1:0] vword = sel_dbl ? {dbl_d[0], addr_ff[2]} : addr_ff[3:2];
  wire [3:0] one_word = 4'h1 << vword;
  assign vm.addr    = vn;
  assign vm.wr_en   = !wr_now ? 4'h0 :
                      (ok_vec | ok_dbl) ? one_word :
                      ok_scal ? dsrf_pkg::scal_wen(view) : 4'h0;
  // scalar stores zero everything above the view
  assign vm.wr_data = ok_scal ?
                      {96'h0, hwdata_in & dsrf_pkg::view_mask(view)} :
                      {4{hwdata_in}};

  wire [63:0] elem_v = dsrf_pkg::elem_get(vm.rd_data, shape, eidx);
  wire [31:0] stat_w = {28'h0, lvl, st32, refused_ff};
  wire [63:0] gpr_v  = gpr_ff[gpr_i];
  wire [63:0] era_v  = era_ff[sys_l];
  wire [63:0] sp_v   = sp_ff[sys_l];

  // read selection; refused and unmapped reads return zero
  wire [31:0] rd_word =
    !ok_any  ? 32'h0 :
    sel_ctrl ? ctrl_ff :
    sel_stat ? stat_w :
    sel_exca ? exc_addr_ff :
    ok_lps   ? lps_ff :
    ok_gpr   ? (addr_ff[2] ? gpr_v[63:32] : gpr_v[31:0]) :
    ok_bank  ? gpr_ff[bank_i][31:0] :
    ok_sst   ? sst_ff[sst_k] :
    ok_era   ? (addr_ff[2] ? era_v[63:32] : era_v[31:0]) :
    ok_sp    ? (addr_ff[2] ? sp_v[63:32] : sp_v[31:0]) :
    ok_scal  ? (vm.rd_data[31:0] & dsrf_pkg::view_mask(view)) :
    ok_elem  ? (addr_ff[2] ? elem_v[63:32] : elem_v[31:0]) :
    vm.rd_data[{vword, 5'h0} +: 32];

  // exception entry and control updates
  wire exc_go   = wr_now & sel_excg & (exc_tgt != 2'h0);
  wire stat_clr = wr_now & sel_stat & hwdata_in[dsrf_pkg::STAT_REFUSED_BIT];
  wire [31:0] nxt_ctrl = exc_go ?
    {ctrl_ff[31:3], exc_tgt, 1'b0} :
    ((wr_now & sel_ctrl) ? (hwdata_in & dsrf_pkg::CTRL_MASK) : ctrl_ff);

  // transfer sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dsrf_pkg::ST_IDLE: if (take) nxt_state = dsrf_pkg::ST_EXEC;
      dsrf_pkg::ST_EXEC: nxt_state = dsrf_pkg::ST_RESP;
      dsrf_pkg::ST_RESP: nxt_state = dsrf_pkg::ST_IDLE;
      default:           nxt_state = dsrf_pkg::ST_IDLE;
    endcase
  end

  // bus side registers; two wait states give the store time to answer
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_ff   <= dsrf_pkg::ST_IDLE;
      addr_ff    <= 12'h0;
      addr_hi_ff <= 1'b0;
      wr_ff      <= 1'b0;
      hready_ff  <= 1'b1;
      hresp_ff   <= 1'b0;
      hrdata_ff  <= 32'h0;
    end else begin
      state_ff  <= nxt_state;
      hready_ff <= (nxt_state == dsrf_pkg::ST_IDLE);
      if (take) begin
        addr_ff    <= haddr_in[11:0];
        addr_hi_ff <= |haddr_in[31:12];
        wr_ff      <= hwrite_in;
      end
      if (state_ff == dsrf_pkg::ST_RESP) hrdata_ff <= rd_word;
    end
  end

  // control, status and legacy state; a refusal beats a clear
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl_ff     <= dsrf_pkg::CTRL_RESET;
      lps_ff      <= dsrf_pkg::LPS_RESET;
      exc_addr_ff <= 32'h0;
      refused_ff  <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      refused_ff <= (exec & !ok_any) | (refused_ff & !stat_clr);
      if (wr_now & sel_exca) exc_addr_ff <= hwdata_in;
      if (wr_now & ok_lps) lps_ff <= hwdata_in & dsrf_pkg::LPS_MASK;
    end
  end

  // general file; exception entry to 64-bit state from 32-bit zeroes upper halves, a control write does not
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < dsrf_pkg::NUM_GPR; i++) gpr_ff[i] <= 64'h0;
    end else begin
      if (exc_go & st32) begin
        for (int i = 0; i < dsrf_pkg::NUM_GPR; i++) begin
          gpr_ff[i][63:32] <= 32'h0;
        end
      end
      if (wr_now & ok_gpr) begin
        if (addr_ff[2]) gpr_ff[gpr_i][63:32] <= hwdata_in;
        else gpr_ff[gpr_i][31:0] <= hwdata_in;
      end
      // word view leaves the upper half untouched
      if (wr_now & ok_bank) gpr_ff[bank_i][31:0] <= hwdata_in;
    end
  end

  // system registers; slots are shared by level so aliases cost nothing
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < dsrf_pkg::NUM_SST; i++) sst_ff[i] <= 32'h0;
      for (int i = 0; i < 4; i++) era_ff[i] <= 64'h0;
      for (int i = 0; i < 3; i++) sp_ff[i] <= 64'h0;
    end else begin
      if (wr_now & ok_sst) sst_ff[sst_k] <= hwdata_in;
      if (wr_now & ok_era) begin
        if (addr_ff[2]) era_ff[sys_l][63:32] <= hwdata_in;
        else era_ff[sys_l][31:0] <= hwdata_in;
      end
      if (wr_now & ok_sp) begin
        if (addr_ff[2]) sp_ff[sys_l][63:32] <= hwdata_in;
        else sp_ff[sys_l][31:0] <= hwdata_in;
      end
      if (exc_go) begin
        sst_ff[exc_tgt - 2'h1] <= lps_ff;
        era_ff[exc_tgt][31:0] <= exc_addr_ff;
        if (st32) era_ff[exc_tgt][63:32] <= 32'h0;
      end
    end
  end

  assign hrdata_out    = hrdata_ff;
  assign hreadyout_out = hready_ff;
  assign hresp_out     = hresp_ff;
  assign state32_out   = ctrl_ff[dsrf_pkg::CTRL_ST32_BIT];
  assign level_out     = ctrl_ff[dsrf_pkg::CTRL_LVL_LSB +: 2];

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_exc_era_upper: assert property (
    exc_go && st32 |=> era_ff[$past(exc_tgt)][63:32] == 32'h0
  ) else $error("return address upper word not cleared");

  a_exc_gpr_upper: assert property (
    exc_go && st32 |=> gpr_ff[30][63:32] == 32'h0 && !st32
  ) else $error("upper halves kept on entry to 64-bit state");

  a_sp_kept_legacy: assert property (
    st32 && !exc_go |=>
    sp_ff[1] == $past(sp_ff[1]) && era_ff[1] == $past(era_ff[1])
  ) else $error("stack pointer or return changed in 32-bit state");

  a_high_vec_hidden: assert property (
    st32 && vm.wr_en != 4'h0 |-> !vm.addr[4]
  ) else $error("high vector written from 32-bit state");

  a_legacy_sst_guard: assert property (
    exec && sel_sst && !st32 && sst_k >= dsrf_pkg::SST_ABT && lvl < 2'h2
    |=> refused_ff
  ) else $error("legacy saved status reached from low level");

  a_scalar_zero_fill: assert property (
    wr_now && ok_scal && view <= dsrf_pkg::VIEW_SNGL
    |-> vm.wr_en == 4'hf && vm.wr_data[127:32] == 96'h0
  ) else $error("scalar store left upper bits");

  a_half_no_arith: assert property (
    exec && sel_scal && fpa && view == dsrf_pkg::VIEW_HALF
    |-> vm.wr_en == 4'h0 ##1 refused_ff
  ) else $error("half view used while arithmetic mode set");

  a_double_pairing: assert property (
    exec && sel_dbl |-> vm.addr == {1'b0, addr_ff[7:4]}
  ) else $error("double view mapped to wrong vector");

  a_bus_two_waits: assert property (
    take |=> !hreadyout_out ##1 !hreadyout_out ##1 hreadyout_out
  ) else $error("ready timing broken");

endmodule

// *** dsrf_pipe_model.sv ***
// dsrf_pipe_model: pipeline-side bus master, single word transfers
// assumes one slave whose ready output is the bus ready
module dsrf_pipe_model (
  input  wire logic        core_clk_in, // core clock
  input  wire logic        hready_in,   // bus ready
  input  wire logic [31:0] hrdata_in,   // read data
  output logic             hsel_out,    // slave select
  output logic      [31:0] haddr_out,   // byte address
  output logic      [1:0]  htrans_out,  // idle or nonseq
  output logic             hwrite_out,  // write when high
  output logic      [2:0]  hsize_out,   // always word
  output logic      [31:0] hwdata_out   // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero; htrans alone qualifies a transfer
  initial begin
    hsel_out   = 1'b1;
    haddr_out  = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out  = 3'h2;
    hwdata_out = 32'h0;
  end
  // one transfer; no latency assumed, only ready ends each phase
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk_in);
    htrans_out <= 2'h2;
    haddr_out  <= a;
    hwrite_out <= w;
    hwdata_out <= ~hwdata_out; // stale data scrambled, never held
    do @(posedge core_clk_in); while (hready_in !== 1'b1);
    htrans_out <= 2'h0;
    hwdata_out <= d;
    do @(posedge core_clk_in); while (hready_in !== 1'b1);
    r = hrdata_in;
  endtask
endmodule

// *** dual_state_register_file_tb_top.sv ***
// dual_state_register_file_tb_top: self-checking bench for dsrf_top
// assumes the pipeline model makes every bus transfer; one clock
module dual_state_register_file_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, hsel, hwrite, hready, hresp, st32;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, lvl;
  logic [2:0]  hsize;
  int          err_count, n_compared;
  // banked homes: mode, 32-bit register, 64-bit index
  logic [4:0]  bmode [7] = '{dsrf_pkg::MODE_FIQ, dsrf_pkg::MODE_IRQ,
    dsrf_pkg::MODE_ABT, dsrf_pkg::MODE_SVC, dsrf_pkg::MODE_UND,
    dsrf_pkg::MODE_HYP, dsrf_pkg::MODE_MON};
  logic [3:0]  breg  [7] = '{4'hc, 4'hd, 4'he, 4'hd, 4'he, 4'hd, 4'he};
  logic [4:0]  bidx  [7] = '{5'h1c, 5'h11, 5'h14, 5'h13, 5'h16, 5'h0f,
    5'h0e};

  dsrf_top uut (.core_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .state32_out(st32), .level_out(lvl));
  dsrf_pipe_model pm (.core_clk_in(clk), .hready_in(hready),
    .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
    .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata));

  // 20 mhz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    pm.xfer(1'b1, a, d, r);
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [31:0] a, e, input string n);
    logic [31:0] r;
    pm.xfer(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic t_reset;
    chk("hresp", 32'h0, {31'h0, hresp});
    rc(32'h0, 32'h0, "ctrl");
    wr(32'h0, 32'h1);
    chk("state32", 32'h1, {31'h0, st32});
    rc(32'h10, 32'h3, "legacy");
    wr(32'h10, 32'hffff_ffff);
    rc(32'h10, 32'h0f0f_fe3f, "legacy_mask");
    $display("reset test done");
  endtask
  task automatic t_bank;
    logic [31:0] ga;
    for (int i = 0; i < 7; i++) begin
      ga = 32'h100 + {24'h0, bidx[i], 3'h0};
      wr(32'h0, 32'h0);
      wr(ga + 32'h4, 32'h5a00_0000 | 32'(i));
      wr(32'h0, 32'h1);
      wr(32'h10, {27'h0, bmode[i]});
      wr(32'h200 + {26'h0, breg[i], 2'h0}, 32'hb000_0000 | 32'(i));
      wr(32'h0, 32'h0);
      rc(ga, 32'hb000_0000 | 32'(i), "bank_word");
      rc(ga + 32'h4, 32'h5a00_0000 | 32'(i), "bank_upper");
    end
    $display("bank test done");
  endtask
  task automatic t_exc;
    wr(32'h0, 32'h2);
    wr(32'h348, 32'h1111_2222);
    wr(32'h12c, 32'h77);
    wr(32'h0, 32'h3);
    wr(32'h10, 32'h0800_0003);
    wr(32'h8, 32'hcafe_0010);
    wr(32'hc, 32'h2);
    chk("state32", 32'h0, {31'h0, st32});
    chk("level", 32'h2, {30'h0, lvl});
    rc(32'h330, 32'hcafe_0010, "hyp_return");
    rc(32'h334, 32'h0, "return_upper");
    rc(32'h304, 32'h0800_0003, "hyp_status");
    rc(32'h12c, 32'h0, "gpr_upper");
    rc(32'h348, 32'h1111_2222, "stack_l1");
    $display("exception test done");
  endtask
  task automatic t_scal;
    logic [31:0] e0;
    for (int v = 0; v < 5; v++) begin
      wr(32'h0, 32'(v) << 3);
      for (int w = 0; w < 4; w++) wr(32'h430 + 32'(4 * w), 32'ha5a5_a5a5);
      wr(32'h60c, 32'h1234_5678);
      e0 = (v == 0) ? 32'h78 : (v == 1) ? 32'h5678 : 32'h1234_5678;
      rc(32'h60c, e0, "scalar_read");
      rc(32'h430, e0, "vec_w0");
      rc(32'h434, (v > 2) ? 32'ha5a5_a5a5 : 32'h0, "vec_w1");
      rc(32'h438, (v > 3) ? 32'ha5a5_a5a5 : 32'h0, "vec_w2");
      rc(32'h43c, (v > 3) ? 32'ha5a5_a5a5 : 32'h0, "vec_w3");
    end
    // vector 3 ends as 0x1234_5678 in word 0; 16-bit lanes of 128 bits
    wr(32'h0, 32'h0000_02c0);
    rc(32'h818, 32'h0000_1234, "elem_lane1");
    wr(32'h0, 32'h0000_1080);
    rc(32'h818, 32'h0, "elem_range");
    $display("scalar test done");
  endtask
  task automatic t_dbl;
    wr(32'h0, 32'h1);
    wr(32'h72c, 32'hd5d5_0001);
    wr(32'h720, 32'hd4d4_0000);
    wr(32'h0, 32'h0);
    rc(32'h42c, 32'hd5d5_0001, "double_high");
    rc(32'h420, 32'hd4d4_0000, "double_low");
    $display("double test done");
  endtask
  task automatic t_ref;
    wr(32'h500, 32'h1616_1616);
    wr(32'h0, 32'h1);
    wr(32'h4, 32'h1);
    wr(32'h500, 32'h0);
    rc(32'h4, 32'h3, "status_v16");
    wr(32'h0, 32'h0);
    rc(32'h500, 32'h1616_1616, "v16_kept");
    wr(32'h4, 32'h1);
    rc(32'h30c, 32'h0, "abt_status");
    rc(32'h4, 32'h1, "status_l0");
    wr(32'h0, 32'h2008);
    rc(32'h60c, 32'h0, "half_arith");
    rc(32'h1000, 32'h0, "unmapped");
    $display("refusal test done");
  endtask

  // main sequence: reset held 16 cycles, then the scenarios
  initial begin
    err_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_bank;
    t_exc;
    t_scal;
    t_dbl;
    t_ref;
    results;
  end
  // watchdog: tests need under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results;
  end
endmodule
